// *** verilog/tdcc_regs.svh ***
// Register addresses, field positions, reset values and limits of the timer.
// Assumes byte addresses on the CPU memory bus; byte registers use data bits 7:0.
`ifndef TDCC_REGS_SVH
`define TDCC_REGS_SVH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define TDCC_ADDR_CNT 16'hFF10
`define TDCC_ADDR_CCA 16'hFF12
`define TDCC_ADDR_CCB 16'hFF14
`define TDCC_ADDR_TMC 16'hFF60
`define TDCC_ADDR_PRM 16'hFF61
`define TDCC_ADDR_CRC 16'hFF62

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define TDCC_CNT_RST 16'h0000
`define TDCC_CNT_MAX 16'hFFFF
`define TDCC_CNT_ONE 16'h0001
`define TDCC_CC_RST 16'h0000
`define TDCC_DATA_RST 16'h0000
`define TDCC_BIT_RST 1'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TDCC_TMC_OVF 0
`define TDCC_TMC_TIM 1
`define TDCC_TMC_MLO 2
`define TDCC_TMC_MHI 3
`define TDCC_CRC_AMODE 0
`define TDCC_CRC_ATRIG 1
`define TDCC_CRC_BMODE 2
`define TDCC_PRM_ESA_LO 4
`define TDCC_PRM_ESA_HI 5
`define TDCC_PRM_ESB_LO 6
`define TDCC_PRM_ESB_HI 7

`endif

// *** verilog/tdcc_pkg.sv ***
// Types shared by the timer modules: modes, edge selects, state records.
// Assumes tdcc_regs.svh supplies all numeric constants.
package tdcc_pkg;

	typedef enum logic [1:0] {
		TDCC_STOP = 2'h0,
		TDCC_FREE = 2'h1,
		TDCC_EDGE_CLR = 2'h2,
		TDCC_MATCH_CLR = 2'h3
	} tdcc_mode_t;

	typedef enum logic [1:0] {
		TDCC_ES_FALL = 2'h0,
		TDCC_ES_RISE = 2'h1,
		TDCC_ES_BAD = 2'h2,
		TDCC_ES_BOTH = 2'h3
	} tdcc_edge_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} tdcc_sync_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic pend;
		logic a_prev;
		logic b_prev;
		tdcc_mode_t mode;
		logic tim;
		logic ovf;
		logic a_cap;
		logic a_trig;
		logic b_cap;
		tdcc_edge_t es_a;
		tdcc_edge_t es_b;
		logic [15:0] rdata;
	} tdcc_top_t;

endpackage

// *** verilog/tdcc_sync.sv ***
// Two-stage synchroniser for one timer input pin.
// Assumes an asynchronous pin; only the second stage leaves the module.
`timescale 1ns/1ps
`include "tdcc_regs.svh"
module tdcc_sync
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Pin
	input wire logic pin_in,
	output logic pin_sync
);
	import tdcc_pkg::*;

	localparam tdcc_sync_t RST_ST = '{s1: `TDCC_BIT_RST, s2: `TDCC_BIT_RST};

	tdcc_sync_t st_ff;
	tdcc_sync_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= RST_ST;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign pin_sync = st_ff.s2;

endmodule

// *** verilog/tdcc_ccr.sv ***
// One capture/compare register with its match detector.
// Assumes count advances are flagged by the caller with the new count value.
`timescale 1ns/1ps
`include "tdcc_regs.svh"
module tdcc_ccr
#(
	parameter int W = 16
)
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Mode and capture
	input wire logic cap_mode,
	input wire logic cap_evt,
	input wire logic [W-1:0] cap_data,
	// Software write
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	// Counter
	input wire logic cnt_adv,
	input wire logic [W-1:0] cnt_new,
	// Results
	output logic [W-1:0] value,
	output logic match
);
	import tdcc_pkg::*;

	typedef struct packed {
		logic [W-1:0] value;
		logic match;
	} tdcc_ccr_st_t;

	localparam tdcc_ccr_st_t RST_ST = '{value: W'(`TDCC_CC_RST), match: `TDCC_BIT_RST};

	tdcc_ccr_st_t st_ff;
	tdcc_ccr_st_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		// Capture beats a software write in the same cycle
		if (cap_mode && cap_evt)
			nxt_st.value = cap_data;
		else if (wr_en)
			nxt_st.value = wr_data;
		// Compare only on a count advance, so a held count fires once
		nxt_st.match = !cap_mode && cnt_adv && (cnt_new == st_ff.value);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= RST_ST;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign value = st_ff.value;
	assign match = st_ff.match;

endmodule

// *** verilog/tdcc_top.sv ***
// 16-bit up-counter with two capture/compare registers and CPU register port.
// Assumes count_tick is a one-cycle prescaled count pulse on clk_sys and
// timer inputs are asynchronous pins.
//
// Contract
// - 16-bit read-only counter increments per count tick
// - Counter read holds count clock for snapshot
// - Counter clears at reset and stop mode
// - Edge-clear mode zeroes counter on input A
// - Match-clear mode zeroes counter at register A
// - Control bit 0 selects register A role
// - Register A compare raises match interrupt A
// - Register A captures on pin A or B
// - Pin A edge select encoding per register
// - Pin B edge select encoding for register A
// - Capture registers take 16-bit writes only
// - Zero compare A fires on counter wrap
// - Lower compare value waits for wraparound
// - Control bit 2 selects register B role
// - Register B compare raises match interrupt B
// - Register B captures only on pin A
// - Zero compare B fires on counter wrap
// - Mode bit zero compare, one capture
// - Mode field selects stop, free, edge, match
`timescale 1ns/1ps
`include "tdcc_regs.svh"
module tdcc_top
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Prescaled count clock
	input wire logic count_tick,
	// Timer input pins
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	// CPU memory bus
	input wire logic [15:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic bus_word,
	input wire logic [15:0] bus_wdata,
	output logic [15:0] bus_rdata,
	// Interrupt requests
	output logic match_irq_a,
	output logic match_irq_b
);
	import tdcc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam tdcc_top_t RST_ST = '{
		cnt: `TDCC_CNT_RST,
		pend: `TDCC_BIT_RST,
		a_prev: `TDCC_BIT_RST,
		b_prev: `TDCC_BIT_RST,
		mode: TDCC_STOP,
		tim: `TDCC_BIT_RST,
		ovf: `TDCC_BIT_RST,
		a_cap: `TDCC_BIT_RST,
		a_trig: `TDCC_BIT_RST,
		b_cap: `TDCC_BIT_RST,
		es_a: TDCC_ES_FALL,
		es_b: TDCC_ES_FALL,
		rdata: `TDCC_DATA_RST
	};

	tdcc_top_t st_ff;
	tdcc_top_t nxt_st;

	logic a_sync;
	logic b_sync;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic a_valid;
	logic a_rev;
	logic b_valid;
	logic running;
	logic rd_cnt;
	logic tick_req;
	logic tick;
	logic edge_clr;
	logic match_clr;
	logic cnt_adv;
	logic [15:0] cnt_new;
	logic ovf_set;
	logic cap_a_evt;
	logic cap_b_evt;
	logic wr_cca;
	logic wr_ccb;
	logic wr_tmc;
	logic wr_crc;
	logic wr_prm;
	logic [15:0] cca_value;
	logic [15:0] ccb_value;
	logic [15:0] rd_mux;

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	tdcc_sync u_sync_a
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.pin_in(timer_input_a),
		.pin_sync(a_sync)
	);

	tdcc_sync u_sync_b
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.pin_in(timer_input_b),
		.pin_sync(b_sync)
	);

	assign a_rise = a_sync && !st_ff.a_prev;
	assign a_fall = !a_sync && st_ff.a_prev;
	assign b_rise = b_sync && !st_ff.b_prev;
	assign b_fall = !b_sync && st_ff.b_prev;

	// Edge select decode; the prohibited code detects nothing
	function automatic logic edge_hit(tdcc_edge_t es, logic rise, logic fall);
		logic hit;
		hit = 1'h0;
		unique case (es)
			TDCC_ES_FALL: hit = fall;
			TDCC_ES_RISE: hit = rise;
			TDCC_ES_BAD: hit = 1'h0;
			TDCC_ES_BOTH: hit = rise || fall;
		endcase
		return hit;
	endfunction

	// pin A valid edge, and reverse phase for register A
	assign a_valid = edge_hit(st_ff.es_a, a_rise, a_fall);
	assign a_rev = (st_ff.es_a != TDCC_ES_BOTH) && edge_hit(st_ff.es_a, a_fall, a_rise);
	// pin B valid edge, same sense for register A
	assign b_valid = edge_hit(st_ff.es_b, b_rise, b_fall);

	// ----------------------------------------------------------------
	// Counter control
	// ----------------------------------------------------------------
	// every mode except stop runs the counter
	assign running = (st_ff.mode != TDCC_STOP);
	// a counter read defers the tick by one cycle
	assign rd_cnt = bus_rd && (bus_addr == `TDCC_ADDR_CNT);
	assign tick_req = running && (count_tick || st_ff.pend);
	assign tick = tick_req && !rd_cnt;
	// valid pin A edge restarts from zero
	assign edge_clr = running && (st_ff.mode == TDCC_EDGE_CLR) && a_valid;
	// match with register A restarts from zero
	assign match_clr = (st_ff.mode == TDCC_MATCH_CLR) && (st_ff.cnt == cca_value);
	assign cnt_adv = tick && !edge_clr;
	// no early restart on a lowered compare; count runs through wrap
	assign cnt_new = match_clr ? `TDCC_CNT_RST : 16'(st_ff.cnt + `TDCC_CNT_ONE);
	// wrap to zero counts as an advance, so zero compare fires
	assign ovf_set = cnt_adv && (st_ff.cnt == `TDCC_CNT_MAX);

	// register A trigger is pin A reverse phase or pin B
	assign cap_a_evt = running && (st_ff.a_trig ? a_rev : b_valid);
	// register B trigger is pin A valid edge only
	assign cap_b_evt = running && a_valid;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// capture registers accept word writes only
	assign wr_cca = bus_wr && bus_word && (bus_addr == `TDCC_ADDR_CCA);
	assign wr_ccb = bus_wr && bus_word && (bus_addr == `TDCC_ADDR_CCB);
	assign wr_tmc = bus_wr && !bus_word && (bus_addr == `TDCC_ADDR_TMC);
	assign wr_crc = bus_wr && !bus_word && (bus_addr == `TDCC_ADDR_CRC);
	assign wr_prm = bus_wr && !bus_word && (bus_addr == `TDCC_ADDR_PRM);

	// ----------------------------------------------------------------
	// Capture/compare registers
	// ----------------------------------------------------------------
	// register A role and compare interrupt
	tdcc_ccr #(.W(16)) u_ccr_a
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.cap_mode(st_ff.a_cap),
		.cap_evt(cap_a_evt),
		.cap_data(st_ff.cnt),
		.wr_en(wr_cca),
		.wr_data(bus_wdata),
		.cnt_adv(cnt_adv),
		.cnt_new(cnt_new),
		.value(cca_value),
		.match(match_irq_a)
	);

	// register B role and compare interrupt
	tdcc_ccr #(.W(16)) u_ccr_b
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.cap_mode(st_ff.b_cap),
		.cap_evt(cap_b_evt),
		.cap_data(st_ff.cnt),
		.wr_en(wr_ccb),
		.wr_data(bus_wdata),
		.cnt_adv(cnt_adv),
		.cnt_new(cnt_new),
		.value(ccb_value),
		.match(match_irq_b)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_mux = `TDCC_DATA_RST;
		unique case (bus_addr)
			`TDCC_ADDR_CNT: rd_mux = st_ff.cnt;
			`TDCC_ADDR_CCA: rd_mux = cca_value;
			`TDCC_ADDR_CCB: rd_mux = ccb_value;
			`TDCC_ADDR_TMC:
			begin
				rd_mux[`TDCC_TMC_MHI:`TDCC_TMC_MLO] = st_ff.mode;
				rd_mux[`TDCC_TMC_TIM] = st_ff.tim;
				rd_mux[`TDCC_TMC_OVF] = st_ff.ovf;
			end
			`TDCC_ADDR_CRC:
			begin
				rd_mux[`TDCC_CRC_AMODE] = st_ff.a_cap;
				rd_mux[`TDCC_CRC_ATRIG] = st_ff.a_trig;
				rd_mux[`TDCC_CRC_BMODE] = st_ff.b_cap;
			end
			`TDCC_ADDR_PRM:
			begin
				rd_mux[`TDCC_PRM_ESA_HI:`TDCC_PRM_ESA_LO] = st_ff.es_a;
				rd_mux[`TDCC_PRM_ESB_HI:`TDCC_PRM_ESB_LO] = st_ff.es_b;
			end
			default: rd_mux = `TDCC_DATA_RST;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.a_prev = a_sync;
		nxt_st.b_prev = b_sync;
		// remember a tick swallowed by a counter read
		nxt_st.pend = tick_req && rd_cnt;
		// stop mode holds the counter at zero
		if (!running)
			nxt_st.cnt = `TDCC_CNT_RST;
		else if (edge_clr)
			nxt_st.cnt = `TDCC_CNT_RST;
		else if (tick)
			nxt_st.cnt = cnt_new;
		// Overflow: hardware set wins over a software clear
		if (wr_tmc)
		begin
			nxt_st.mode = tdcc_mode_t'(bus_wdata[`TDCC_TMC_MHI:`TDCC_TMC_MLO]);
			nxt_st.tim = bus_wdata[`TDCC_TMC_TIM];
			nxt_st.ovf = bus_wdata[`TDCC_TMC_OVF] || ovf_set;
		end
		else
			nxt_st.ovf = st_ff.ovf || ovf_set;
		if (wr_crc)
		begin
			nxt_st.a_cap = bus_wdata[`TDCC_CRC_AMODE];
			nxt_st.a_trig = bus_wdata[`TDCC_CRC_ATRIG];
			nxt_st.b_cap = bus_wdata[`TDCC_CRC_BMODE];
		end
		if (wr_prm)
		begin
			nxt_st.es_a = tdcc_edge_t'(bus_wdata[`TDCC_PRM_ESA_HI:`TDCC_PRM_ESA_LO]);
			nxt_st.es_b = tdcc_edge_t'(bus_wdata[`TDCC_PRM_ESB_HI:`TDCC_PRM_ESB_LO]);
		end
		if (bus_rd)
			nxt_st.rdata = rd_mux;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= RST_ST;
		else if (ce)
			st_ff <= nxt_st;
	end

	assign bus_rdata = st_ff.rdata;

endmodule

// *** sim/tdcc_chk.sv ***
// Assertions on the timer's register port and match pulses.
// Assumes it is bound to tdcc_top and sees its ports only.
`timescale 1ns/1ps
`include "tdcc_regs.svh"
module tdcc_chk
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Inputs
	input wire logic count_tick,
	input wire logic [15:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic bus_word,
	input wire logic [15:0] bus_wdata,
	// Outputs
	input wire logic [15:0] bus_rdata,
	input wire logic match_irq_a,
	input wire logic match_irq_b
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ----------------
	// Bus sequences
	// ----------------
	sequence rd_s(a);
		bus_rd && bus_addr == a;
	endsequence
	sequence wr_s(a, w);
		bus_wr && bus_word == w && bus_addr == a;
	endsequence
	// ----------------
	// Checks
	// ----------------
	irq_a_pulse_a: assert property (match_irq_a |=> !match_irq_a)
		else $error("irq a high two cycles");
	irq_b_pulse_a: assert property (match_irq_b |=> !match_irq_b)
		else $error("irq b high two cycles");
	irq_a_cause_a: assert property (match_irq_a |-> $past(count_tick) || $past(count_tick, 2))
		else $error("irq a without count tick");
	irq_b_cause_a: assert property (match_irq_b |-> $past(count_tick) || $past(count_tick, 2))
		else $error("irq b without count tick");
	rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved without read");
	stop_clear_a: assert property ((wr_s(`TDCC_ADDR_TMC, 1'b0) and bus_wdata[3:2] == 2'h0)
		##2 rd_s(`TDCC_ADDR_CNT) |=> bus_rdata == `TDCC_CNT_RST) else $error("count not cleared");
	word_write_a: assert property (wr_s(`TDCC_ADDR_CCA, 1'b1) ##2 rd_s(`TDCC_ADDR_CCA)
		|=> bus_rdata == $past(bus_wdata, 3)) else $error("word write lost");
	byte_refuse_a: assert property (rd_s(`TDCC_ADDR_CCA) ##2 wr_s(`TDCC_ADDR_CCA, 1'b0)
		##2 rd_s(`TDCC_ADDR_CCA) |=> $stable(bus_rdata)) else $error("byte write taken");
	byte_upper_a: assert property (bus_rd && bus_addr inside {`TDCC_ADDR_TMC, `TDCC_ADDR_PRM,
		`TDCC_ADDR_CRC} |=> bus_rdata[15:8] == 8'h00) else $error("byte reg upper bits set");
endmodule

bind tdcc_top tdcc_chk u_tdcc_chk (.clk_sys(clk_sys), .rst_n(rst_n), .count_tick(count_tick),
	.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_word(bus_word),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .match_irq_a(match_irq_a),
	.match_irq_b(match_irq_b));

// *** sim/tdcc_pin_src.sv ***
// Pulse source model for the two timer input pins.
// Assumes the bench calls set_pin; pins idle low, change at falling edges.
`timescale 1ns/1ps
module tdcc_pin_src
(
	// Clock
	input wire logic clk_sys,
	// Pins
	output logic pin_a,
	output logic pin_b
);
	initial
	begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	task automatic set_pin(input bit sel, input logic v);
		@(negedge clk_sys);
		if (sel)
			pin_b = v;
		else
			pin_a = v;
	endtask
endmodule

// *** sim/tdcc_top_tb.sv ***
// Self-checking bench for the dual capture/compare timer.
// Assumes the design, pin source model and checker are compiled first.
`timescale 1ns/1ps
`include "tdcc_regs.svh"
module tdcc_top_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic count_tick = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_rd = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_word = 1'b0;
	logic [15:0] bus_wdata = 16'h0000;
	logic [15:0] bus_rdata;
	logic match_irq_a;
	logic match_irq_b;
	logic pin_a;
	logic pin_b;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #10 clk_sys = ~clk_sys;
	tdcc_top u_tdcc_top
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(1'b1),
		.count_tick(count_tick),
		.timer_input_a(pin_a),
		.timer_input_b(pin_b),
		.bus_addr(bus_addr),
		.bus_rd(bus_rd),
		.bus_wr(bus_wr),
		.bus_word(bus_word),
		.bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata),
		.match_irq_a(match_irq_a),
		.match_irq_b(match_irq_b)
	);
	tdcc_pin_src u_tdcc_pin_src
	(
		.clk_sys(clk_sys),
		.pin_a(pin_a),
		.pin_b(pin_b)
	);
	// ----------------
	// Helpers
	// ----------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(negedge clk_sys);
		bus_addr = a;
		bus_wdata = d;
		bus_word = w;
		bus_wr = 1'b1;
		@(negedge clk_sys);
		bus_wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk_sys);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk_sys);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(negedge clk_sys);
			count_tick = 1'b1;
		end
		@(negedge clk_sys);
		count_tick = 1'b0;
	endtask
	task automatic wait_irq(input logic [1:0] m, input int lim, output int n);
		n = 0;
		while (n < lim && ({match_irq_b, match_irq_a} & m) == 2'b00)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset();
		logic [15:0] d;
		rd(`TDCC_ADDR_CNT, d);
		chk("count", `TDCC_CNT_RST, d);
		rd(`TDCC_ADDR_TMC, d);
		chk("mode", 16'h0000, d);
		rd(`TDCC_ADDR_CRC, d);
		chk("ctrl", 16'h0000, d);
		rd(16'hFF00, d);
		chk("unmapped", 16'h0000, d);
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [15:0] d;
		logic [15:0] a;
		for (int i = 0; i < 2; i++)
		begin
			a = i ? `TDCC_ADDR_CCB : `TDCC_ADDR_CCA;
			wr(a, 16'hA5C3, 1'b1);
			rd(a, d);
			chk("word write", 16'hA5C3, d);
			wr(a, 16'h0011, 1'b0);
			rd(a, d);
			chk("byte write", 16'hA5C3, d);
		end
		$display("test regs done");
	endtask
	task automatic t_count();
		logic [15:0] d;
		wr(`TDCC_ADDR_TMC, 16'h0004, 1'b0);
		ticks(3);
		rd(`TDCC_ADDR_CNT, d);
		chk("count up", 16'h0003, d);
		wr(`TDCC_ADDR_CNT, 16'h1234, 1'b1);
		rd(`TDCC_ADDR_CNT, d);
		chk("count ro", 16'h0003, d);
		count_tick = 1'b1;
		rd(`TDCC_ADDR_CNT, d);
		count_tick = 1'b0;
		chk("snapshot", 16'h0004, d);
		rd(`TDCC_ADDR_CNT, d);
		chk("no lost tick", 16'h0005, d);
		wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
		rd(`TDCC_ADDR_CNT, d);
		chk("stop clear", 16'h0000, d);
		$display("test count done");
	endtask
	task automatic t_cmp(input logic [15:0] crc, input bit cap);
		int n;
		wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_CCA, 16'h0005, 1'b1);
		wr(`TDCC_ADDR_CCB, 16'h0007, 1'b1);
		wr(`TDCC_ADDR_CRC, crc, 1'b0);
		wr(`TDCC_ADDR_TMC, 16'h0004, 1'b0);
		count_tick = 1'b1;
		wait_irq(2'b11, 20, n);
		chk("first irq", cap ? 16'd20 : 16'd5, 16'(n));
		if (!cap)
		begin
			chk("irq a", 16'h0001, {15'h0, match_irq_a});
			wait_irq(2'b10, 20, n);
			chk("a to b", 16'd2, 16'(n));
			wr(`TDCC_ADDR_CCA, 16'h0003, 1'b1);
			wait_irq(2'b01, 40, n);
			chk("lowered", 16'd40, 16'(n));
		end
		count_tick = 1'b0;
		$display("test compare done");
	endtask
	task automatic t_wrap();
		int n;
		logic [15:0] d;
		wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_CCA, 16'h0000, 1'b1);
		wr(`TDCC_ADDR_CCB, 16'h0000, 1'b1);
		wr(`TDCC_ADDR_CRC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_TMC, 16'h0004, 1'b0);
		count_tick = 1'b1;
		wait_irq(2'b01, 70000, n);
		chk("wrap a", 16'h0001, {15'h0, n == 65536});
		chk("wrap b", 16'h0001, {15'h0, match_irq_b});
		rd(`TDCC_ADDR_TMC, d);
		chk("overflow flag", 16'h0005, d);
		count_tick = 1'b0;
		$display("test wrap done");
	endtask
	task automatic t_mclr();
		int n;
		wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_CCA, 16'h0003, 1'b1);
		wr(`TDCC_ADDR_CCB, 16'h0009, 1'b1);
		wr(`TDCC_ADDR_CRC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_TMC, 16'h000C, 1'b0);
		count_tick = 1'b1;
		wait_irq(2'b01, 20, n);
		@(negedge clk_sys);
		wait_irq(2'b01, 20, n);
		chk("period", 16'd4, 16'(n + 1));
		count_tick = 1'b0;
		$display("test match clear done");
	endtask
	task automatic t_eclr();
		logic [15:0] d;
		wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
		wr(`TDCC_ADDR_PRM, 16'h0010, 1'b0);
		wr(`TDCC_ADDR_TMC, 16'h0008, 1'b0);
		ticks(20);
		rd(`TDCC_ADDR_CNT, d);
		chk("edge mode count", 16'd20, d);
		u_tdcc_pin_src.set_pin(1'b0, 1'b1);
		repeat (6) @(negedge clk_sys);
		rd(`TDCC_ADDR_CNT, d);
		chk("edge clear", 16'h0000, d);
		u_tdcc_pin_src.set_pin(1'b0, 1'b0);
		$display("test edge clear done");
	endtask
	task automatic t_cap();
		logic [15:0] d;
		logic [15:0] prm [8] = '{16'h0000, 16'h0010, 16'h0020, 16'h0030,
			16'h0000, 16'h0040, 16'h0080, 16'h00C0};
		logic [15:0] ea [8] = '{16'h0000, 16'h0001, 16'hBEEF, 16'hBEEF,
			16'h0001, 16'h0000, 16'hBEEF, 16'h0001};
		logic [15:0] eb [8] = '{16'h0001, 16'h0000, 16'hBEEF, 16'h0001,
			16'hBEEF, 16'hBEEF, 16'hBEEF, 16'hBEEF};
		for (int i = 0; i < 8; i++)
		begin
			wr(`TDCC_ADDR_TMC, 16'h0000, 1'b0);
			wr(`TDCC_ADDR_PRM, prm[i], 1'b0);
			wr(`TDCC_ADDR_CRC, i < 4 ? 16'h0007 : 16'h0005, 1'b0);
			wr(`TDCC_ADDR_CCA, 16'hBEEF, 1'b1);
			wr(`TDCC_ADDR_CCB, 16'hBEEF, 1'b1);
			wr(`TDCC_ADDR_TMC, 16'h0004, 1'b0);
			u_tdcc_pin_src.set_pin(i >= 4, 1'b1);
			repeat (6) @(negedge clk_sys);
			ticks(1);
			u_tdcc_pin_src.set_pin(i >= 4, 1'b0);
			repeat (6) @(negedge clk_sys);
			rd(`TDCC_ADDR_CCA, d);
			chk("capture a", ea[i], d);
			rd(`TDCC_ADDR_CCB, d);
			chk("capture b", eb[i], d);
		end
		$display("test capture done");
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_regs();
		t_count();
		t_cmp(16'h0000, 1'b0);
		t_cmp(16'h0005, 1'b1);
		t_mclr();
		t_eclr();
		t_cap();
		t_wrap();
		report_and_stop();
	end
endmodule
